// >>> design/vcra_load_seq.sv
// load sequencer: copies the table into the arbiter and tracks coherency
`timescale 1ns/1ns
module vcra_load_seq
    import vcra_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic load_go, // one-cycle qualified load request
    input wire logic tbl_wr, // software wrote a table entry
    output logic arb_latch, // pulse per latch cycle to the arbiter
    output logic arb_table_status, // table not yet coherent
    output logic busy // load in progress
);
    vcra_load_st_t st_r;
    logic [3:0] cnt_r;

    // ****************************************
    // load sequence
    // ****************************************
    // fixed count models the arbiter walking the table entries
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= VCRA_IDLE;
            cnt_r <= 4'h0;
        end else begin
            case (st_r)
                VCRA_IDLE: begin
                    if (load_go) begin
                        st_r <= VCRA_LOAD;
                        cnt_r <= VCRA_LOAD_CYCLES - 4'h1;
                    end
                end
                VCRA_LOAD: begin
                    if (cnt_r == 4'h0) begin
                        st_r <= VCRA_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: st_r <= VCRA_IDLE;
            endcase
        end
    end

    assign busy = (st_r == VCRA_LOAD);
    assign arb_latch = busy;

    // status: an entry write wins over the completion clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_table_status <= 1'b0;
        end else if (tbl_wr) begin
            arb_table_status <= 1'b1;
        end else if (busy && cnt_r == 4'h0) begin
            arb_table_status <= 1'b0;
        end
    end

    // the sequencer stays busy for the whole load, then drops
    sequence s_busy_span;
        busy [*4] ##1 !busy;
    endsequence

    property p_load_len;
        @(posedge sys_clk) disable iff (!rst_n)
        (load_go && !busy) |=> s_busy_span;
    endproperty
    a_load_len: assert property (p_load_len) else $error("load length wrong");

    property p_sts_set;
        @(posedge sys_clk) disable iff (!rst_n)
        tbl_wr |=> arb_table_status;
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("status not set on write");

    property p_sts_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (arb_table_status && !busy) |=> arb_table_status;
    endproperty
    a_sts_hold: assert property (p_sts_hold) else $error("status cleared without load");
endmodule

// >>> design/vcra_pkg.sv
// package: offsets, field layout and reset values of the vc resource registers
package vcra_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] VCRA_OFS_CAP = 12'h110;
    localparam logic [11:0] VCRA_OFS_CTL = 12'h114;
    localparam logic [11:0] VCRA_OFS_STS = 12'h118;

    // ****************************************
    // field positions
    // ****************************************
    localparam int VCRA_LOAD_BIT = 16;
    localparam int VCRA_SEL_LSB = 17;
    localparam int VCRA_OFFSET_LSB = 24;
    localparam int VCRA_ENABLE_BIT = 31;
    localparam int VCRA_STS_BIT = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] VCRA_ARBCAP_RST = 8'h01;
    localparam logic [7:0] VCRA_OFFSET_RST = 8'h00;
    localparam logic [7:0] VCRA_TCMAP_RST = 8'hff;
    localparam logic [2:0] VCRA_SEL_RST = 3'h0;
    localparam logic [2:0] VCRA_CHAN_ID = 3'h0;
    localparam logic VCRA_CHAN_EN = 1'b1;

    // ****************************************
    // cycles the arbiter takes to latch a table
    // ****************************************
    localparam logic [3:0] VCRA_LOAD_CYCLES = 4'h4;

    // scheme select value that the fixed round robin corresponds to (no table used)
    localparam logic [2:0] VCRA_SEL_HWRR = 3'h0;

    typedef enum logic [1:0] {
        VCRA_IDLE = 2'b00,
        VCRA_LOAD = 2'b01
    } vcra_load_st_t;

    // true when a selected scheme consults the arbitration table
    function automatic logic vcra_uses_table(input logic [2:0] sel, input logic [7:0] cap);
        vcra_uses_table = (sel != VCRA_SEL_HWRR) && cap[sel];
    endfunction
endpackage

// >>> design/vcra_rd_mux.sv
// read mux: assembles the register words with fixed fields
`timescale 1ns/1ns
module vcra_rd_mux
    import vcra_pkg::*;
(
    input wire logic [11:0] addr, // byte address
    input wire logic [7:0] arb_cap, // capability field
    input wire logic [7:0] tbl_ofs, // table offset field
    input wire logic [7:0] tc_map, // traffic class map
    input wire logic [2:0] arb_sel, // scheme select
    input wire logic tbl_sts, // table status
    output logic [31:0] rdata // assembled word
);
    // constant fields are wired here so no flop can hold a wrong value
    always_comb begin
        rdata = 32'h0000_0000;
        case (addr)
            VCRA_OFS_CAP: begin
                rdata[7:0] = arb_cap;
                rdata[31:24] = tbl_ofs;
                // bits 14, 15 and 22:16 stay zero
                rdata[15:14] = 2'h0;
                rdata[22:16] = 7'h00;
            end
            VCRA_OFS_CTL: begin
                rdata[7:0] = tc_map;
                rdata[VCRA_LOAD_BIT] = 1'b0;
                rdata[19:17] = arb_sel;
                rdata[26:24] = VCRA_CHAN_ID;
                rdata[VCRA_ENABLE_BIT] = VCRA_CHAN_EN;
            end
            VCRA_OFS_STS: rdata[VCRA_STS_BIT] = tbl_sts;
            default: rdata = 32'h0000_0000;
        endcase
    end
endmodule

// >>> design/vcra_regs.sv
// top: vc resource capability and control register bank
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module vcra_regs
    import vcra_pkg::*;
(
    input wire logic sys_clk, // 10 MHz core clock
    input wire logic rst_n, // async reset, active low
    input wire logic [11:0] reg_addr, // byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic unlock, // device level unlock of lockable fields
    input wire logic tbl_wr, // a table entry was written
    output logic [7:0] tc_map, // classes mapped to the channel
    output logic [2:0] arb_sel, // selected arbitration scheme
    output logic [7:0] tbl_offset, // table offset in 16-byte units
    output logic arb_latch, // arbiter latch strobe
    output logic arb_table_status // table incoherent
);
    import vcra_pkg::*;

    // ****************************************
    // register map and field layout
    // ****************************************
    // capability word at 0x110:
    //   7:0   arbitration capability, one bit per scheme, lockable
    //   13:8  reserved, reads zero
    //   14    advanced switching capability, tied low
    //   15    reject snoop capability, tied low
    //   22:16 max time slots, tied low since no time-based scheme exists here
    //   23    reserved, reads zero
    //   31:24 table offset in 16-byte units, lockable
    // control word at 0x114:
    //   7:0   traffic class map, bit 0 tied high, bits 7:1 writable
    //   15:8  reserved, reads zero
    //   16    load command, a write of one starts it, always reads zero
    //   19:17 arbitration select, stored as written
    //   23:20 reserved, reads zero
    //   26:24 channel identifier, tied low for the single channel
    //   30:27 reserved, reads zero
    //   31    channel enable, tied high
    // status word at 0x118:
    //   0     table status, set by an entry write, cleared when a load ends
    //   31:1  reserved, reads zero
    // every other address reads zero and drops writes

    // hazards and trade-offs:
    // - the load command is qualified against the select already stored, so
    //   a word that writes a new select and the load bit together tests the
    //   old select; software writes the select first, then the load bit
    // - a load that arrives while the sequencer is busy is dropped rather
    //   than queued; software waits for the status bit before the next one
    // - an entry write in the cycle that ends a load wins over the clear,
    //   so that last write is never reported as latched
    // - the select is not checked against the capability; a select with no
    //   advertised scheme behind it simply never lets a load through
    // - read data are registered and shown for one cycle only, zero
    //   otherwise, so a late sampler sees zero rather than a stale word
    // - unlock is a level from the device; while it is low neither lockable
    //   field takes a write, and the rest of the bank is unaffected
    // - the constant fields other than the class 0 map bit live in the read mux, not in flops, so no
    //   reset glitch or stray write can ever show them wrong

    logic [7:0] arb_cap_r;
    logic [7:0] tbl_ofs_r;
    logic [7:0] tc_map_r;
    logic [2:0] arb_sel_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_word;
    logic wr_cap;
    logic wr_ctl;
    logic load_pulse;
    logic load_go;
    logic busy;
    logic tbl_scheme;
    logic [3:0] busy_run_r;

    // ****************************************
    // write decode
    // ****************************************
    assign wr_cap = reg_wr && (reg_addr == VCRA_OFS_CAP);
    assign wr_ctl = reg_wr && (reg_addr == VCRA_OFS_CTL);
    // load is a pure pulse; zero writes produce nothing
    assign load_pulse = wr_ctl && reg_wdata[VCRA_LOAD_BIT];
    // one decode of the table test, shared by the gate and the load checks; p_noload decodes it again
    assign tbl_scheme = vcra_uses_table(arb_sel_r, arb_cap_r);
    // ignored when the current scheme does not use a table
    assign load_go = load_pulse && tbl_scheme;

    // lockable capability fields
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_cap_r <= VCRA_ARBCAP_RST;
            tbl_ofs_r <= VCRA_OFFSET_RST;
        end else if (wr_cap && unlock) begin
            arb_cap_r <= reg_wdata[7:0];
            tbl_ofs_r <= reg_wdata[31:24];
        end
    end

    // control fields; class 0 bit never written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_map_r <= VCRA_TCMAP_RST;
            arb_sel_r <= VCRA_SEL_RST;
        end else if (wr_ctl) begin
            tc_map_r[7:1] <= reg_wdata[7:1];
            arb_sel_r <= reg_wdata[19:17];
        end
    end

    // ****************************************
    // load sequencer and read path
    // ****************************************
    vcra_load_seq u_seq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load_go(load_go),
        .tbl_wr(tbl_wr),
        .arb_latch(arb_latch),
        .arb_table_status(arb_table_status),
        .busy(busy)
    );

    vcra_rd_mux u_mux (
        .addr(reg_addr),
        .arb_cap(arb_cap_r),
        .tbl_ofs(tbl_ofs_r),
        .tc_map(tc_map_r),
        .arb_sel(arb_sel_r),
        .tbl_sts(arb_table_status),
        .rdata(rd_word)
    );

    // read data registered, shown only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_r <= rd_word;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;
    assign tc_map = tc_map_r;
    assign arb_sel = arb_sel_r;
    assign tbl_offset = tbl_ofs_r;

    // ****************************************
    // checks
    // ****************************************
    property p_tc0;
        @(posedge sys_clk) disable iff (!rst_n)
        tc_map_r[0];
    endproperty
    a_tc0: assert property (p_tc0) else $error("class 0 bit changed");

    property p_lock;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_cap && !unlock) |=> $stable(arb_cap_r) && $stable(tbl_ofs_r);
    endproperty
    a_lock: assert property (p_lock) else $error("locked field written");

    property p_noload;
        @(posedge sys_clk) disable iff (!rst_n)
        (load_pulse && !vcra_uses_table(arb_sel_r, arb_cap_r) && !busy) |=> !busy;
    endproperty
    a_noload: assert property (p_noload) else $error("load without table scheme");

    property p_zero_wr;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_ctl && !reg_wdata[VCRA_LOAD_BIT] && !busy) |=> !busy;
    endproperty
    a_zero_wr: assert property (p_zero_wr) else $error("zero write started load");

    property p_ctl_rd;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == VCRA_OFS_CTL) |=>
            !reg_rdata[16] && reg_rdata[31] && reg_rdata[26:24] == 3'h0;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("ctl fixed bits");

    property p_cap_rd;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == VCRA_OFS_CAP) |=> reg_rdata[23:8] == 16'h0000;
    endproperty
    a_cap_rd: assert property (p_cap_rd) else $error("cap zero bits");

    // ****************************************
    // load and status checks
    // ****************************************
    // consecutive latch cycles; saturating so a stuck sequencer cannot wrap back
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_run_r <= 4'h0;
        end else if (!busy) begin
            busy_run_r <= 4'h0;
        end else if (busy_run_r != 4'hf) begin
            busy_run_r <= busy_run_r + 4'h1;
        end
    end

    // a qualified load taken while the sequencer is idle
    sequence s_load_req;
        load_pulse && tbl_scheme && !busy;
    endsequence

    // the latch strobe stands for the whole load span, then drops
    sequence s_latch_span;
        arb_latch [*4] ##1 !arb_latch;
    endsequence

    // the arbiter sees exactly one latch span per accepted load
    property p_load_span;
        @(posedge sys_clk) disable iff (!rst_n)
        s_load_req |=> s_latch_span;
    endproperty
    a_load_span: assert property (p_load_span) else $error("latch span wrong");

    // a load that ends with no entry write beside it leaves the table coherent
    property p_load_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_load_req ##4 !tbl_wr) |=> !arb_table_status;
    endproperty
    a_load_clear: assert property (p_load_clear) else $error("status kept");

    // an entry write during a load must never be lost
    property p_sts_win;
        @(posedge sys_clk) disable iff (!rst_n)
        (tbl_wr && busy) |=> arb_table_status;
    endproperty
    a_sts_win: assert property (p_sts_win) else $error("status lost");

    // status rises only from an entry write
    property p_sts_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(arb_table_status) |-> $past(tbl_wr);
    endproperty
    a_sts_rise: assert property (p_sts_rise) else $error("status rose unprompted");

    // status falls only at the end of a load, never on its own
    property p_sts_fall;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(arb_table_status) |-> $past(busy) && !$past(tbl_wr);
    endproperty
    a_sts_fall: assert property (p_sts_fall) else $error("status fell early");

    // a load never starts without a written one and a table scheme
    property p_load_cause;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(busy) |-> $past(load_pulse) && $past(tbl_scheme);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("unqualified load");

    // nothing starts the sequencer but a qualified request
    property p_no_spurious;
        @(posedge sys_clk) disable iff (!rst_n)
        (!load_go && !busy) |=> !busy;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious load");

    // the latch span never runs past its length, even under repeated loads
    property p_run_len;
        @(posedge sys_clk) disable iff (!rst_n)
        busy_run_r <= VCRA_LOAD_CYCLES;
    endproperty
    a_run_len: assert property (p_run_len) else $error("latch span too long");

    // ****************************************
    // register field checks
    // ****************************************
    // an unlocked capability write lands in both lockable fields
    property p_cap_take;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_cap && unlock) |=>
            arb_cap_r == $past(reg_wdata[7:0]) && tbl_ofs_r == $past(reg_wdata[31:24]);
    endproperty
    a_cap_take: assert property (p_cap_take) else $error("capability not taken");

    // the lockable fields move on nothing but an unlocked capability write
    property p_cap_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        !(wr_cap && unlock) |=> $stable(arb_cap_r) && $stable(tbl_ofs_r);
    endproperty
    a_cap_keep: assert property (p_cap_keep) else $error("lockable field moved");

    // a control write lands in the map bits above class 0 and in the select
    property p_ctl_take;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ctl |=>
            tc_map_r[7:1] == $past(reg_wdata[7:1]) && arb_sel_r == $past(reg_wdata[19:17]);
    endproperty
    a_ctl_take: assert property (p_ctl_take) else $error("control not taken");

    // with no control write the map and select stay put
    property p_ctl_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        !wr_ctl |=> $stable(tc_map_r) && $stable(arb_sel_r);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("control moved");

    // read data stand only in the cycle after a strobe
    property p_rd_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

    // a capability read returns the stored lockable fields
    property p_rd_cap;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == VCRA_OFS_CAP) |=>
            reg_rdata[7:0] == $past(arb_cap_r) && reg_rdata[31:24] == $past(tbl_ofs_r);
    endproperty
    a_rd_cap: assert property (p_rd_cap) else $error("capability read wrong");

    // a control read returns map and select, reserved bits zero
    property p_rd_ctl;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == VCRA_OFS_CTL) |=>
            reg_rdata[7:0] == $past(tc_map_r) && reg_rdata[19:17] == $past(arb_sel_r) &&
            reg_rdata[15:8] == 8'h00 && reg_rdata[23:20] == 4'h0 && reg_rdata[30:27] == 4'h0;
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

    // a status read returns the flag alone
    property p_rd_sts;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == VCRA_OFS_STS) |=>
            reg_rdata == {31'h0000_0000, $past(arb_table_status)};
    endproperty
    a_rd_sts: assert property (p_rd_sts) else $error("status read wrong");

    // unmapped reads return zero
    property p_rd_hole;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr != VCRA_OFS_CAP && reg_addr != VCRA_OFS_CTL &&
            reg_addr != VCRA_OFS_STS) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read nonzero");
endmodule

// >>> dv/test_vcra_regs.sv
// testbench: register bus checks of the vc resource capability and control bank
`timescale 1ns/1ns
module test_vcra_regs;
    import vcra_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic unlock = 1'b0;
    logic tbl_wr = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] tc_map;
    logic [2:0] arb_sel;
    logic [7:0] tbl_offset;
    logic arb_latch;
    logic arb_table_status;
    int num_errors = 0;
    int total_checks = 0;

    // ****************************************
    // clock, design
    // ****************************************
    // 10 MHz core clock
    always #50 sys_clk = ~sys_clk;

    vcra_regs u_vcra_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unlock(unlock),
        .tbl_wr(tbl_wr), .tc_map(tc_map), .arb_sel(arb_sel), .tbl_offset(tbl_offset),
        .arb_latch(arb_latch), .arb_table_status(arb_table_status)
    );

    // ****************************************
    // tasks
    // ****************************************
    // one comparison, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single-cycle write, taken at the edge that ends the strobe
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // one-cycle table entry write notice
    task automatic tbl_touch();
        @(posedge sys_clk);
        tbl_wr <= 1'b1;
        @(posedge sys_clk);
        tbl_wr <= 1'b0;
    endtask

    // count latch cycles after a control write; status must hold while latching
    task automatic obs_load(input int exp_n);
        int n;
        n = 0;
        repeat (10) begin
            #1;
            if (arb_latch === 1'b1) begin
                n++;
                chk({31'h0, arb_table_status}, 32'h00000001);
            end
            @(posedge sys_clk);
        end
        chk(n, exp_n);
    endtask

    // the single place where the run ends
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    // the sequence needs about 90 cycles; allow over twenty times that
    initial begin
        #(2000 * 100);
        num_errors++;
        finish_test();
    end

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(VCRA_OFS_CAP, 32'h00000001);
        rd_chk(VCRA_OFS_CTL, 32'h800000ff);
        chk({24'h0, tc_map}, 32'h000000ff);
        chk({29'h0, arb_sel}, 32'h00000000);
        rd_chk(VCRA_OFS_STS, 32'h00000000);
        // locked: capability and offset must not move
        wr_reg(VCRA_OFS_CAP, 32'hffffffff);
        rd_chk(VCRA_OFS_CAP, 32'h00000001);
        chk({24'h0, tbl_offset}, 32'h00000000);
        tbl_touch();
        rd_chk(VCRA_OFS_STS, 32'h00000001);
        // reset scheme is fixed round robin, which needs no table
        wr_reg(VCRA_OFS_CTL, 32'h00010000);
        obs_load(0);
        wr_reg(VCRA_OFS_CTL, 32'h00000000);
        obs_load(0);
        chk({24'h0, tc_map}, 32'h00000001);
        rd_chk(VCRA_OFS_CTL, 32'h80000001);
        rd_chk(VCRA_OFS_STS, 32'h00000001);
        // unlocked: writable fields take, fixed and reserved bits stay zero
        unlock <= 1'b1;
        wr_reg(VCRA_OFS_CAP, 32'hffffffff);
        rd_chk(VCRA_OFS_CAP, 32'hff0000ff);
        chk({24'h0, tbl_offset}, 32'h000000ff);
        // scheme 2 selected but not advertised: no load
        wr_reg(VCRA_OFS_CAP, 32'h12000003);
        wr_reg(VCRA_OFS_CTL, 32'h00040000);
        wr_reg(VCRA_OFS_CTL, 32'h00050000);
        obs_load(0);
        // scheme 2 advertised: a real load, reserved bits set on purpose
        wr_reg(VCRA_OFS_CAP, 32'h12000005);
        wr_reg(VCRA_OFS_CTL, 32'hfff5fffe);
        obs_load(int'(VCRA_LOAD_CYCLES));
        rd_chk(VCRA_OFS_STS, 32'h00000000);
        rd_chk(VCRA_OFS_CTL, 32'h800400ff);
        chk({29'h0, arb_sel}, 32'h00000002);
        chk({24'h0, tbl_offset}, 32'h00000012);
        rd_chk(12'h11c, 32'h00000000);
        // relock and try again
        unlock <= 1'b0;
        wr_reg(VCRA_OFS_CAP, 32'h00000000);
        rd_chk(VCRA_OFS_CAP, 32'h12000005);
        finish_test();
    end
endmodule
